// file: design/hsps_top.sv
// Digital power-up sequencer of a hot swap controller.
// Assumes comparator and pin levels are asynchronous; all are synchronised here.
`timescale 1ns/1ps

// Summary of operation
// - Hold logic reset until supply and regulator good
// - Charge timer capacitor once above undervoltage
// - Discharge only at 1 V and 27 ms
// - Timer below 0.2 V makes gate ready
// - FET health check done during insertion
// - Charge gate only if health check passed
// - Power good needs all six conditions
// - Gate drive loss drops power good after 100 ms
// - Overcurrent gives latch-off or retry by pin
// - Severe short turns gate off within 320 ns
// - First two address pins decode four levels
// - Third address pin is a plain logic bit
// - Insertion delay never shorter than 27 ms
// - Retry low retries after 10 s, else latch
module hsps_top #(
  parameter int unsigned POR_CYCLES   = hsps_pkg::POR_CYC,
  parameter int unsigned PGD_CYCLES   = hsps_pkg::PGD_CYC,
  parameter int unsigned RETRY_CYCLES = hsps_pkg::RETRY_CYC
) (
  input  wire logic                    ref_clk,         // 20 MHz clock
  input  wire logic                    rstn,            // Sync reset, active low
  input  wire logic                    supply_ok,       // Supply above UVLO
  input  wire logic                    regulator_ok,    // internal_regulator started
  input  wire hsps_pkg::hsps_cmp_type  cmp,             // Comparator levels
  input  wire logic                    severe_oc,       // Severe short comparator
  input  wire logic                    retry_select_n,  // Low selects auto-retry
  input  wire logic [1:0]              addr_one_lvl,    // addr_pin_one level code
  input  wire logic [1:0]              addr_two_lvl,    // addr_pin_two level code
  input  wire logic                    addr_pin_three,  // Two-level address pin
  output logic                         logic_rst_n,     // Internal reset, active low
  output hsps_pkg::hsps_drv_type       drv,             // Timer and gate drive
  output logic                         power_ok_out,    // Power good
  output logic                         fault_out_n,     // Fault, active low
  output hsps_pkg::hsps_addr_type      dev_addr         // Decoded device address
);
  import hsps_pkg::*;

  localparam int CW = $clog2(RETRY_CYCLES + 1);
  localparam int NS = $bits(hsps_cmp_type) + 8;

  // Two-flop synchronisers on every asynchronous input
  logic [NS-1:0] raw_s, s1_q, s2_q;
  assign raw_s = {cmp, supply_ok, regulator_ok, retry_select_n, addr_pin_three,
                  addr_one_lvl, addr_two_lvl};
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw_s;
      s2_q <= s1_q;
    end
  end

  hsps_cmp_type c;
  logic       sup_s, reg_s, rty_n_s, a3_s, run_ok;
  logic [1:0] a1_s, a2_s;
  assign {c, sup_s, reg_s, rty_n_s, a3_s, a1_s, a2_s} = s2_q;
  // Insertion runs only while enabled and the input sits inside its window
  assign run_ok = c.enable && c.input_low_compare && !c.input_high_compare;

  // Severe short: separate fast path, two-flop synchronised then registered out (150 ns < 320 ns)
  logic soc1_q, soc2_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      soc1_q <= 1'b0;
      soc2_q <= 1'b0;
    end else begin
      soc1_q <= severe_oc;
      soc2_q <= soc1_q;
    end
  end

  // Internal reset release
  logic rel_q;
  always_ff @(posedge ref_clk) begin
    if (!rstn)
      rel_q <= 1'b0;
    else
      rel_q <= sup_s & reg_s;
  end
  assign logic_rst_n = rel_q;

  // Sequencer
  hsps_state_type st_q;
  logic [CW-1:0]  cnt_q;
  logic           health_fail_q;
  logic           soc_trip_q;
  logic           oc_fault_q;

  always_ff @(posedge ref_clk) begin
    if (!rstn || !rel_q) begin
      st_q          <= HSPS_RESET;
      cnt_q         <= '0;
      health_fail_q <= 1'b0;
    end else begin
      unique case (st_q)
        HSPS_RESET: begin
          cnt_q         <= '0;
          health_fail_q <= 1'b0;
          if (run_ok)
            st_q <= HSPS_CHARGE;
        end
        HSPS_CHARGE: begin
          if (cnt_q < CW'(POR_CYCLES))
            cnt_q <= cnt_q + 1'b1;
          if (c.fet_health_bad)
            health_fail_q <= 1'b1;
          if (!run_ok)
            st_q <= HSPS_RESET;
          else if (c.timer_above_1v && cnt_q >= CW'(POR_CYCLES))
            st_q <= HSPS_DISCHARGE;
        end
        HSPS_DISCHARGE: begin
          if (c.fet_health_bad)
            health_fail_q <= 1'b1;
          if (!run_ok)
            st_q <= HSPS_RESET;
          else if (!c.timer_above_0v2) begin
            cnt_q <= '0;
            if (health_fail_q || c.fet_health_bad)
              st_q <= HSPS_LATCHED;
            else
              st_q <= HSPS_GATE_ON;
          end
        end
        HSPS_GATE_ON: begin
          if (!run_ok)
            st_q <= HSPS_RESET;
          else if (oc_fault_q || soc_trip_q) begin
            cnt_q <= '0;
            st_q  <= rty_n_s ? HSPS_LATCHED : HSPS_FAULT_WAIT;
          end
        end
        HSPS_FAULT_WAIT: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CW'(RETRY_CYCLES - 1))
            st_q <= HSPS_RESET;
        end
        HSPS_LATCHED: begin
          if (!c.enable)
            st_q <= HSPS_RESET;
        end
        default: st_q <= HSPS_RESET;
      endcase
    end
  end

  // Fault latches, cleared when a new insertion starts
  always_ff @(posedge ref_clk) begin
    if (!rstn || !rel_q || st_q == HSPS_RESET) begin
      soc_trip_q <= 1'b0;
      oc_fault_q <= 1'b0;
    end else begin
      if (soc2_q)
        soc_trip_q <= 1'b1;
      if (c.overcurrent && st_q == HSPS_GATE_ON)
        oc_fault_q <= 1'b1;
    end
  end

  // Drive outputs
  always_ff @(posedge ref_clk) begin
    if (!rstn)
      drv <= '0;
    else begin
      drv.timer_charge    <= rel_q && st_q == HSPS_CHARGE;
      drv.timer_discharge <= rel_q && st_q == HSPS_DISCHARGE;
      drv.gate_charge     <= rel_q && st_q == HSPS_GATE_ON && !soc2_q &&
                             !oc_fault_q && !soc_trip_q;
      drv.gate_fast_off   <= soc2_q | soc_trip_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn)
      fault_out_n <= 1'b1;
    else
      fault_out_n <= !(oc_fault_q || health_fail_q);
  end

  // Power good with deglitch on gate-drive loss only
  logic [CW-1:0] pgd_q;
  logic          others_ok;
  assign others_ok = rel_q && c.output_sense_input && c.enable && c.input_low_compare &&
                     !c.input_high_compare && fault_out_n && st_q == HSPS_GATE_ON;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      power_ok_out <= 1'b0;
      pgd_q        <= '0;
    end else if (!others_ok) begin
      power_ok_out <= 1'b0;
      pgd_q        <= '0;
    end else if (c.gate_above_4v) begin
      power_ok_out <= 1'b1;
      pgd_q        <= '0;
    end else if (power_ok_out) begin
      if (pgd_q >= CW'(PGD_CYCLES - 1))
        power_ok_out <= 1'b0;
      else
        pgd_q <= pgd_q + 1'b1;
    end
  end

  // Address straps after synchronisation; level codes map straight onto address bits
  always_ff @(posedge ref_clk) begin
    if (!rstn)
      dev_addr <= '0;
    else begin
      dev_addr.addr_pin_one   <= a1_s;
      dev_addr.addr_pin_two   <= a2_s;
      dev_addr.addr_pin_three <= a3_s;
    end
  end

endmodule

// file: design/hsps_pkg.sv
// Package for the hot swap power-up sequencer: states, timing constants, carriers.
// Assumes a 20 MHz reference clock; analog comparators are outside the block.
package hsps_pkg;

  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned POR_MIN_MS      = 27;     // Least insertion delay
  localparam int unsigned PG_DEGLITCH_MS  = 100;    // Gate-drive loss deglitch
  localparam int unsigned RETRY_S         = 10;     // Auto-retry wait
  localparam int unsigned SOC_RESP_NS     = 320;    // Severe overcurrent response bound
  localparam int unsigned SYNC_STAGES     = 2;

  localparam int unsigned POR_CYC   = POR_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned PGD_CYC   = PG_DEGLITCH_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_CYC = RETRY_S * CLK_HZ;
  localparam int unsigned SOC_CYC   = (SOC_RESP_NS * (CLK_HZ / 1000000)) / 1000;

  localparam logic [1:0] ADDR_GND  = 2'h0;
  localparam logic [1:0] ADDR_RES  = 2'h1;
  localparam logic [1:0] ADDR_OPEN = 2'h2;
  localparam logic [1:0] ADDR_REG  = 2'h3;

  typedef enum logic [2:0] {
    HSPS_RESET,
    HSPS_CHARGE,
    HSPS_DISCHARGE,
    HSPS_GATE_ON,
    HSPS_FAULT_WAIT,
    HSPS_LATCHED
  } hsps_state_type;

  // Comparator levels from the analog front end
  typedef struct packed {
    logic enable;              // Enable pin
    logic output_sense_input;  // Output sense above 1 V
    logic input_low_compare;   // Undervoltage input above 1 V
    logic input_high_compare;  // Overvoltage input above 1 V
    logic gate_above_4v;       // Gate above sense_negative_node by 4 V
    logic timer_above_1v;      // Timer capacitor reached high threshold
    logic timer_above_0v2;     // Timer capacitor above low threshold
    logic fet_health_bad;      // FET health check failing
    logic overcurrent;         // Timed overcurrent fault
  } hsps_cmp_type;

  // Timer capacitor and gate drive commands to the analog side
  typedef struct packed {
    logic timer_charge;        // 3 uA source on
    logic timer_discharge;     // 100 uA sink on
    logic gate_charge;         // Gate pull-up on
    logic gate_fast_off;       // Fast gate discharge
  } hsps_drv_type;

  // Level-decoded address pins: {one_hi, one_lo}, {two_hi, two_lo}
  typedef struct packed {
    logic [1:0] addr_pin_one;
    logic [1:0] addr_pin_two;
    logic       addr_pin_three;
  } hsps_addr_type;

endpackage

// file: tb/hsps_properties.sv
// Port checker for the hot swap power-up sequencer.
// Assumes a bind to hsps_top with the same count parameters.
`timescale 1ns/1ps
module hsps_properties #(
  parameter int unsigned POR_CYCLES   = 20,
  parameter int unsigned PGD_CYCLES   = 30,
  parameter int unsigned RETRY_CYCLES = 50
) (
  input wire logic                    ref_clk,        // Clock
  input wire logic                    rstn,           // Reset
  input wire logic                    supply_ok,      // Supply good
  input wire logic                    regulator_ok,   // Regulator good
  input wire hsps_pkg::hsps_cmp_type  cmp,            // Comparators
  input wire logic                    severe_oc,      // Short
  input wire logic                    retry_select_n, // Retry pin
  input wire logic [1:0]              addr_one_lvl,   // Level one
  input wire logic [1:0]              addr_two_lvl,   // Level two
  input wire logic                    addr_pin_three, // Logic bit
  input wire logic                    logic_rst_n,    // Internal reset
  input wire hsps_pkg::hsps_drv_type  drv,            // Drive
  input wire logic                    power_ok_out,   // Power good
  input wire logic                    fault_out_n,    // Fault
  input wire hsps_pkg::hsps_addr_type dev_addr        // Address
);
  import hsps_pkg::*;
  int unsigned low_q;
  logic        others_ok;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  assign others_ok = cmp.enable & cmp.output_sense_input & cmp.input_low_compare
                     & !cmp.input_high_compare & fault_out_n & !severe_oc;
  // Consecutive cycles with gate drive lost
  always_ff @(posedge ref_clk) begin
    if (!rstn || cmp.gate_above_4v) low_q <= 0;
    else low_q <= low_q + 1;
  end
  rst_release_a: assert property ($rose(logic_rst_n) |->
    $past(supply_ok, 3) && $past(regulator_ok, 3)) else $error("reset released early");
  gate_order_a: assert property ($rose(drv.gate_charge) |->
    $past(drv.timer_discharge)) else $error("gate charged before insertion end");
  health_block_a: assert property (cmp.fet_health_bad [*4] |->
    !$rose(drv.gate_charge)) else $error("gate charged with bad health");
  pg_cond_a: assert property ($rose(power_ok_out) |->
    $past(others_ok && cmp.gate_above_4v, 3)) else $error("power good without conditions");
  pg_drop_a: assert property (power_ok_out && (!cmp.enable || cmp.input_high_compare)
    |-> ##[1:4] !power_ok_out) else $error("power good not dropped");
  pg_hold_a: assert property ($fell(power_ok_out) && $past(others_ok, 5) && others_ok
    |-> low_q >= PGD_CYCLES) else $error("power good dropped too soon");
  soc_off_a: assert property ($rose(severe_oc) |->
    ##[1:6] drv.gate_fast_off && !drv.gate_charge) else $error("short not cut off");
  addr_map_a: assert property ((logic_rst_n && $stable(addr_one_lvl) && $stable(addr_two_lvl)
    && $stable(addr_pin_three)) [*4] |-> dev_addr == {addr_one_lvl, addr_two_lvl, addr_pin_three})
    else $error("address decode wrong");
  gate_cov: cover property ($rose(drv.gate_charge));
  pg_cov: cover property ($rose(power_ok_out));
  soc_cov: cover property ($rose(drv.gate_fast_off));
endmodule

// file: tb/hsps_far_side.sv
// Far-side model: timer capacitor and FET gate seen through comparators.
// Assumes drive levels from the sequencer; updates on the falling edge.
`timescale 1ns/1ps
module hsps_far_side (
  input  wire logic                   ref_clk,   // Clock
  input  wire hsps_pkg::hsps_drv_type drv,       // Drive commands
  input  wire logic                   lose_gate, // Force gate drive loss
  output logic                        t_hi,      // Timer at 1 V
  output logic                        t_lo,      // Timer above 0.2 V
  output logic                        g_on       // Gate above 4 V
);
  import hsps_pkg::*;
  int lvl = 0;
  int gc = 0;
  always @(negedge ref_clk) begin
    if (drv.timer_charge) lvl <= lvl + 1;
    else if (drv.timer_discharge) lvl <= (lvl > 1) ? lvl - 2 : 0;
    else lvl <= 0;
    gc <= drv.gate_charge ? gc + 1 : 0;
  end
  assign t_hi = lvl >= 10;
  assign t_lo = lvl >= 2;
  assign g_on = gc > 4 && !lose_gate;
endmodule

// file: tb/hsps_top_bench.sv
// Self-checking bench for the power-up sequencer with short counts.
// Assumes hsps_top, hsps_far_side and hsps_properties are compiled first.
`timescale 1ns/1ps
module hsps_top_bench;
  import hsps_pkg::*;
  logic ref_clk = 1'h0, rstn = 1'h0, supply_ok = 1'h0, regulator_ok = 1'h0, severe_oc = 1'h0;
  logic retry_select_n = 1'h1, addr_pin_three = 1'h0, en = 1'h0, ihc = 1'h0, hb = 1'h0;
  logic oc = 1'h0, lose = 1'h0, t_hi, t_lo, g_on, logic_rst_n, power_ok_out, fault_out_n;
  logic [1:0] addr_one_lvl = 2'h0, addr_two_lvl = 2'h0;
  hsps_drv_type drv;
  hsps_cmp_type cmp;
  hsps_addr_type dev_addr;
  int n_fail = 0, samples_checked = 0, k;
  always #25 ref_clk = ~ref_clk;
  assign cmp = {en, en, en, ihc, g_on, t_hi, t_lo, hb, oc};
  hsps_top #(.POR_CYCLES(20), .PGD_CYCLES(30), .RETRY_CYCLES(50)) DUT (.*);
  hsps_far_side far (.ref_clk(ref_clk), .drv(drv), .lose_gate(lose), .t_hi(t_hi),
                     .t_lo(t_lo), .g_on(g_on));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic conclude;
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic start;
    en = 1'h0;
    tick(8);
    en = 1'h1;
    k = 0;
    for (int i = 0; i < 200 && !drv.timer_discharge; i++) begin
      tick(1);
      k += drv.timer_charge;
    end
    chk(drv.timer_discharge, 8'h01);
    chk(k >= 20, 1);
    for (int i = 0; i < 100 && !power_ok_out; i++) tick(1);
    chk({drv.gate_charge, power_ok_out}, 8'h03);
  endtask
  initial begin
    tick(5);
    rstn = 1'h1;
    tick(10);
    chk({logic_rst_n, fault_out_n, power_ok_out, drv}, 8'h20);
    supply_ok = 1'h1;
    regulator_ok = 1'h1;
    tick(6);
    chk(logic_rst_n, 1);
    start();
    lose = 1'h1;
    tick(25);
    chk(power_ok_out, 1);
    tick(15);
    chk(power_ok_out, 0);
    lose = 1'h0;
    start();
    ihc = 1'h1;
    tick(4);
    chk(power_ok_out, 0);
    ihc = 1'h0;
    start();
    severe_oc = 1'h1;
    tick(6);
    chk({drv.gate_fast_off, drv.gate_charge}, 8'h02);
    tick(6);
    severe_oc = 1'h0;
    hb = 1'h1;
    en = 1'h0;
    tick(8);
    en = 1'h1;
    tick(80);
    chk(drv.gate_charge, 0);
    chk(fault_out_n, 0);
    hb = 1'h0;
    for (int r = 0; r < 2; r++) begin
      retry_select_n = r[0];
      start();
      oc = 1'h1;
      for (int i = 0; i < 20 && fault_out_n; i++) tick(1);
      oc = 1'h0;
      chk(fault_out_n, 0);
      tick(30);
      chk(drv.timer_charge, 0);
      tick(30);
      chk(drv.timer_charge, !r[0]);
    end
    for (int i = 0; i < 4; i++) begin
      addr_one_lvl = i[1:0];
      addr_two_lvl = 2'h3 - i[1:0];
      addr_pin_three = i[0];
      tick(6);
      chk(dev_addr, {i[1:0], 2'h3 - i[1:0], i[0]});
    end
    conclude();
  end
  initial begin
    #1000000;
    n_fail++;
    conclude();
  end
endmodule
bind hsps_top hsps_properties #(.POR_CYCLES(POR_CYCLES), .PGD_CYCLES(PGD_CYCLES),
                                .RETRY_CYCLES(RETRY_CYCLES)) props (.*);
